// ---- include/iwwd_pkg.sv ----
package iwwd_pkg;

   // ---------------------------------------------------------------
   // bus and field widths, synchroniser depth
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int KEY_W = 16;
   localparam int CNT_W = 12;
   localparam int PRS_W = 3;
   localparam int CR_W = 6;
   localparam int PSC_W = 9;
   localparam int DIV_W = 10;
   localparam int SR_W = 6;
   localparam int SYNC_N = 3;

   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_KEY = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_RELOAD = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_WINDOW = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h24;

   // ---------------------------------------------------------------
   // key command codes
   // ---------------------------------------------------------------
   localparam logic [KEY_W-1:0] KEY_START = 16'hcccc;
   localparam logic [KEY_W-1:0] KEY_REFRESH = 16'haaaa;
   localparam logic [KEY_W-1:0] KEY_UNLOCK = 16'h5555;
   localparam logic [KEY_W-1:0] KEY_STOP1 = 16'h5a5a;
   localparam logic [KEY_W-1:0] KEY_STOP2 = 16'ha5a5;

   // ---------------------------------------------------------------
   // control field positions and status bit positions
   // ---------------------------------------------------------------
   localparam int CR_PAUSE = 5;
   localparam int CR_IE = 4;
   localparam int CR_ACTION = 3;
   localparam int SR_RELOAD = 5;
   localparam int SR_RUN = 4;
   localparam int SR_OVF = 3;
   localparam int SR_WINB = 2;
   localparam int SR_ARRB = 1;
   localparam int SR_CRB = 0;

   // ---------------------------------------------------------------
   // reset values and prescaler base
   // ---------------------------------------------------------------
   localparam logic [CNT_W-1:0] CNT_FULL = 12'hfff;
   localparam logic [CNT_W-1:0] RELOAD_RST = 12'hfff;
   localparam logic [CNT_W-1:0] WINDOW_RST = 12'hfff;
   localparam logic [CR_W-1:0] CTRL_RST = 6'h00;
   localparam logic [DIV_W-1:0] DIV_BASE = 10'h004;

endpackage

// ---- design/iwwd_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module iwwd_top (
   input wire logic MCLK_I,
   input wire logic RSTN_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [iwwd_pkg::ADDR_W-1:0] PADDR_I,
   input wire logic [iwwd_pkg::DATA_W-1:0] PWDATA_I,
   output logic [iwwd_pkg::DATA_W-1:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic OSC_I,
   input wire logic DEEP_SLEEP_I,
   output logic SYS_RESET_REQ_O,
   output logic OVF_IRQ_O
);
   import iwwd_pkg::*;

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic [SYNC_N-1:0] osc_sync_q;
   logic [SYNC_N-1:0] slp_sync_q;
   logic osc_lvl_q, slp_lvl_q;
   logic osc_tick;
   logic lock_q, stop_arm_q;
   logic start_p_q, refr_p_q, stop_p_q, wrel_p_q;
   logic cr_busy_q, arr_busy_q, win_busy_q;
   logic [CR_W-1:0] cr_sh_q, cr_act_q, cr_nx;
   logic [CNT_W-1:0] arr_sh_q, arr_act_q, arr_nx;
   logic [CNT_W-1:0] win_sh_q, win_act_q, win_nx;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [PSC_W-1:0] psc_q, psc_d;
   logic run_q, ovf_q;
   logic rst_req_q, irq_q;
   logic [DATA_W-1:0] prdata_q;
   logic wr_en, rd_setup, cfg_ok, key_wr;
   logic sel_key, sel_cr, sel_arr, sel_sr, sel_win, sel_cnt, mapped;
   logic [KEY_W-1:0] key;
   logic cr_wr, arr_wr, win_wr, win_chg;
   logic [DIV_W-1:0] div_last;
   logic paused, psc_end, cnt_tick, any_reload, ovf_evt;
   logic win_mode, early;
   logic [SR_W-1:0] status;
   logic [DATA_W-1:0] rd_mux;

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   // three stages; a level is believed once stages two and three agree
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         osc_sync_q <= '0;
         slp_sync_q <= '0;
      end else begin
         osc_sync_q <= {osc_sync_q[SYNC_N-2:0], OSC_I};
         slp_sync_q <= {slp_sync_q[SYNC_N-2:0], DEEP_SLEEP_I};
      end
   end

   // filtered levels of oscillator and deep sleep
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         osc_lvl_q <= 1'b0;
         slp_lvl_q <= 1'b0;
      end else begin
         if (osc_sync_q[1] == osc_sync_q[2]) osc_lvl_q <= osc_sync_q[2];
         if (slp_sync_q[1] == slp_sync_q[2]) slp_lvl_q <= slp_sync_q[2];
      end
   end

   // one tick per filtered rising oscillator edge
   assign osc_tick = (osc_sync_q[1] == osc_sync_q[2]) & osc_sync_q[2] &
                     ~osc_lvl_q;

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   // zero wait state slave; read data captured in the setup cycle
   assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
   assign rd_setup = PSEL_I & ~PENABLE_I & ~PWRITE_I;
   assign sel_key = (PADDR_I == OFF_KEY);
   assign sel_cr = (PADDR_I == OFF_CTRL);
   assign sel_arr = (PADDR_I == OFF_RELOAD);
   assign sel_sr = (PADDR_I == OFF_STATUS);
   assign sel_win = (PADDR_I == OFF_WINDOW);
   assign sel_cnt = (PADDR_I == OFF_COUNT);
   assign mapped = sel_key | sel_cr | sel_arr | sel_sr | sel_win | sel_cnt;
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
   assign key = PWDATA_I[KEY_W-1:0];
   assign key_wr = wr_en & sel_key;

   // config writes need unlock, a running watchdog and an idle busy flag
   assign cfg_ok = ~lock_q & run_q;
   assign cr_wr = wr_en & sel_cr & cfg_ok & ~cr_busy_q;
   assign arr_wr = wr_en & sel_arr & cfg_ok & ~arr_busy_q;
   assign win_wr = wr_en & sel_win & cfg_ok & ~win_busy_q;
   assign win_chg = win_wr & (PWDATA_I[CNT_W-1:0] != win_sh_q);

   // ---------------------------------------------------------------
   // key command handling
   // ---------------------------------------------------------------
   // any key but unlock relocks, which covers start, refresh and stop
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         lock_q <= 1'b1;
         stop_arm_q <= 1'b0;
      end else if (key_wr) begin
         lock_q <= (key != KEY_UNLOCK);
         stop_arm_q <= (key == KEY_STOP1);
      end
   end

   // pending commands wait for the next oscillator edge; set beats clear
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         start_p_q <= 1'b0;
         refr_p_q <= 1'b0;
         stop_p_q <= 1'b0;
         wrel_p_q <= 1'b0;
      end else begin
         start_p_q <= (key_wr & (key == KEY_START)) |
                      (start_p_q & ~osc_tick);
         refr_p_q <= (key_wr & (key == KEY_REFRESH)) |
                     (refr_p_q & ~osc_tick);
         stop_p_q <= (key_wr & stop_arm_q & (key == KEY_STOP2)) |
                     (stop_p_q & ~osc_tick);
         wrel_p_q <= win_chg | (wrel_p_q & ~osc_tick);
      end
   end

   // ---------------------------------------------------------------
   // configuration shadows and busy flags
   // ---------------------------------------------------------------
   // shadows take bus writes; active copies follow on oscillator edge
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         cr_sh_q <= CTRL_RST;
         arr_sh_q <= RELOAD_RST;
         win_sh_q <= WINDOW_RST;
      end else begin
         if (cr_wr) cr_sh_q <= PWDATA_I[CR_W-1:0];
         if (arr_wr) arr_sh_q <= PWDATA_I[CNT_W-1:0];
         if (win_wr) win_sh_q <= PWDATA_I[CNT_W-1:0];
      end
   end

   // busy holds from the write until the oscillator edge that applies it
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         cr_busy_q <= 1'b0;
         arr_busy_q <= 1'b0;
         win_busy_q <= 1'b0;
      end else begin
         cr_busy_q <= cr_wr | (cr_busy_q & ~osc_tick);
         arr_busy_q <= arr_wr | (arr_busy_q & ~osc_tick);
         win_busy_q <= win_wr | (win_busy_q & ~osc_tick);
      end
   end

   // values in force after this oscillator edge
   assign cr_nx = cr_busy_q ? cr_sh_q : cr_act_q;
   assign arr_nx = arr_busy_q ? arr_sh_q : arr_act_q;
   assign win_nx = win_busy_q ? win_sh_q : win_act_q;

   // active copies seen by the counter
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         cr_act_q <= CTRL_RST;
         arr_act_q <= RELOAD_RST;
         win_act_q <= WINDOW_RST;
      end else if (osc_tick) begin
         cr_act_q <= cr_nx;
         arr_act_q <= arr_nx;
         win_act_q <= win_nx;
      end
   end

   // ---------------------------------------------------------------
   // prescaler and counter
   // ---------------------------------------------------------------
   // divide ratio is four shifted left by the prescale code
   assign div_last = (DIV_BASE << cr_act_q[PRS_W-1:0]) - DIV_BASE /
                     DIV_BASE;
   assign paused = cr_act_q[CR_PAUSE] & slp_lvl_q;
   assign psc_end = ({1'b0, psc_q} == div_last);
   assign cnt_tick = osc_tick & run_q & ~paused & psc_end;
   assign any_reload = start_p_q | refr_p_q | wrel_p_q;
   assign ovf_evt = cnt_tick & (cnt_q == '0) & ~any_reload &
                    ~stop_p_q;
   assign win_mode = (win_act_q < arr_act_q);
   assign early = osc_tick & refr_p_q & run_q & win_mode &
                  (cnt_q > win_act_q);

   // next prescaler phase
   always_comb begin
      psc_d = psc_q;
      if (osc_tick & start_p_q) psc_d = '0;
      else if (osc_tick & run_q & ~paused) psc_d = psc_end ? '0 :
                                                   psc_q + 1'b1;
   end

   // next count: start, then reloads, then decrement, reloading from arr_act_q at zero
   always_comb begin
      cnt_d = cnt_q;
      if (osc_tick & start_p_q) cnt_d = CNT_FULL;
      else if (osc_tick & (refr_p_q | wrel_p_q)) cnt_d = arr_nx;
      else if (cnt_tick) cnt_d = (cnt_q == '0) ? arr_act_q :
                                  cnt_q - 1'b1;
   end

   // counter, prescaler, run and overflow state
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         psc_q <= '0;
         cnt_q <= CNT_FULL;
         run_q <= 1'b0;
         ovf_q <= 1'b0;
      end else begin
         psc_q <= psc_d;
         cnt_q <= cnt_d;
         if (osc_tick & start_p_q) run_q <= 1'b1;
         else if (osc_tick & stop_p_q) run_q <= 1'b0;
         ovf_q <= ovf_evt | (ovf_q & ~(osc_tick & start_p_q));
      end
   end

   // ---------------------------------------------------------------
   // overflow actions
   // ---------------------------------------------------------------
   // one cycle pulses toward reset and interrupt controllers
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rst_req_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         rst_req_q <= (ovf_evt & ~cr_act_q[CR_ACTION]) | early;
         irq_q <= ovf_evt & cr_act_q[CR_ACTION] & cr_act_q[CR_IE];
      end
   end
   assign SYS_RESET_REQ_O = rst_req_q;
   assign OVF_IRQ_O = irq_q;

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   // status word and read multiplexer
   assign status = {refr_p_q | wrel_p_q, run_q, ovf_q,
                    win_busy_q, arr_busy_q, cr_busy_q};
   assign rd_mux = sel_cr ? {{(DATA_W-CR_W){1'b0}}, cr_sh_q} :
                   sel_arr ? {{(DATA_W-CNT_W){1'b0}}, arr_sh_q} :
                   sel_sr ? {{(DATA_W-SR_W){1'b0}}, status} :
                   sel_win ? {{(DATA_W-CNT_W){1'b0}}, win_sh_q} :
                   sel_cnt ? {{(DATA_W-CNT_W){1'b0}}, cnt_q} :
                   '0;

   // read data register
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) prdata_q <= '0;
      else if (rd_setup) prdata_q <= rd_mux;
   end
   assign PRDATA_O = prdata_q;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RSTN_I);

   property p_start;
      osc_tick && start_p_q |=> run_q && cnt_q == CNT_FULL && !ovf_q;
   endproperty
   a_start: assert property (p_start)
      else $error("start did not load full count");

   property p_refresh;
      osc_tick && refr_p_q && !start_p_q |=> cnt_q == $past(arr_nx);
   endproperty
   a_refresh: assert property (p_refresh)
      else $error("refresh did not reload counter");

   property p_overflow;
      ovf_evt |=> ovf_q && cnt_q == $past(arr_act_q);
   endproperty
   a_overflow: assert property (p_overflow)
      else $error("overflow did not flag and reload");

   property p_reset_act;
      ovf_evt && !cr_act_q[CR_ACTION] |=> SYS_RESET_REQ_O && !OVF_IRQ_O;
   endproperty
   a_reset_act: assert property (p_reset_act)
      else $error("overflow with reset action gave no reset");

   property p_irq_act;
      ovf_evt && cr_act_q[CR_ACTION] |=>
         OVF_IRQ_O == $past(cr_act_q[CR_IE]);
   endproperty
   a_irq_act: assert property (p_irq_act)
      else $error("interrupt action mismatch");

   property p_pause;
      paused && !(osc_tick && any_reload) |=> $stable(cnt_q);
   endproperty
   a_pause: assert property (p_pause)
      else $error("counter moved in paused deep sleep");

   property p_lock;
      key_wr && key != KEY_UNLOCK |=> lock_q ##1 !cr_wr;
   endproperty
   a_lock: assert property (p_lock)
      else $error("lock not engaged after key");

   property p_stop;
      key_wr && key == KEY_STOP2 && !stop_arm_q |=> !stop_p_q;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop taken without first key");

   property p_busy;
      arr_busy_q && !osc_tick |=> arr_busy_q;
   endproperty
   a_busy: assert property (p_busy)
      else $error("reload busy dropped before apply");

   property p_unlock;
      key_wr && key == KEY_UNLOCK |=> !lock_q;
   endproperty
   a_unlock: assert property (p_unlock)
      else $error("unlock key did not open config registers");

   property p_reload_flag;
      key_wr && key == KEY_REFRESH |=> status[SR_RELOAD];
   endproperty
   a_reload_flag: assert property (p_reload_flag)
      else $error("reload flag not raised by refresh key");

   property p_window;
      early |=> SYS_RESET_REQ_O;
   endproperty
   a_window: assert property (p_window)
      else $error("early refresh gave no reset");

   c_overflow: cover property (ovf_evt);
   c_early: cover property (early);
   c_stop: cover property (osc_tick && stop_p_q && run_q);
   c_pause: cover property (run_q && paused);

endmodule // iwwd_top

`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
   import iwwd_pkg::*;

   // ---------------------------------------------------------------
   // stimulus, observation and the design under test
   // ---------------------------------------------------------------
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic osc = 1'b0;
   logic deep = 1'b0;
   wire logic [DATA_W-1:0] prdata;
   wire logic pready;
   wire logic pslverr;
   wire logic sys_rst;
   wire logic irq;
   int err_count = 0;
   int checks_done = 0;
   int n_rst = 0;
   int n_irq = 0;
   int cyc = 0;
   int t_irq = 0;
   logic [DATA_W-1:0] rd;
   logic err;

   iwwd_top uut (
      .MCLK_I(mclk), .RSTN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .OSC_I(osc), .DEEP_SLEEP_I(deep), .SYS_RESET_REQ_O(sys_rst),
      .OVF_IRQ_O(irq)
   );

   // ---------------------------------------------------------------
   // clocks and pulse monitor
   // ---------------------------------------------------------------
   // bus clock at 100 ns period
   initial begin
      forever #50 mclk = ~mclk;
   end

   // scaled oscillator: one rising edge every 8 bus cycles
   initial begin
      forever begin
         repeat (4) @(posedge mclk);
         osc <= ~osc;
      end
   end

   // count output pulses and stamp the latest interrupt
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (sys_rst === 1'b1) n_rst <= n_rst + 1;
      if (irq === 1'b1) begin
         n_irq <= n_irq + 1;
         t_irq <= cyc;
      end
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic final_report();
      if (err_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [DATA_W-1:0] e, g);
      checks_done++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask

   // one apb transfer; result kept in rd and err
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input string nm, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] e);
      apb(1'b0, a, '0);
      chk(nm, e, rd);
   endtask

   // poll status until the masked flags clear
   task automatic wait_free(input logic [DATA_W-1:0] m);
      repeat (200) begin
         apb(1'b0, OFF_STATUS, '0);
         if ((rd & m) === '0) break;
      end
      chk("status busy", '0, rd & m);
   endtask

   task automatic wait_irq();
      int n0;
      n0 = n_irq;
      repeat (3000) begin
         @(posedge mclk);
         if (n_irq != n0) break;
      end
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      rdchk("status", OFF_STATUS, '0);
      rdchk("control", OFF_CTRL, '0);
      rdchk("reload", OFF_RELOAD, 32'h0000_0fff);
      rdchk("window", OFF_WINDOW, 32'h0000_0fff);
      rdchk("count", OFF_COUNT, 32'h0000_0fff);
      rdchk("key", OFF_KEY, '0);
      apb(1'b0, 8'h40, '0);
      chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped data", '0, rd);
   endtask

   task automatic t_start();
      wr(OFF_KEY, KEY_UNLOCK);
      wr(OFF_CTRL, 32'h18);
      repeat (30) @(posedge mclk);
      rdchk("early control", OFF_CTRL, '0);
      wr(OFF_KEY, KEY_START);
      repeat (100) @(posedge mclk);
      rdchk("run flag", OFF_STATUS, 32'h10);
      apb(1'b0, OFF_COUNT, '0);
      chk("count falls", 1, rd < 32'hfff && rd > 32'hff0);
      wr(OFF_RELOAD, 32'h123);
      repeat (30) @(posedge mclk);
      rdchk("locked reload", OFF_RELOAD, 32'h0000_0fff);
   endtask

   task automatic t_config();
      wr(OFF_KEY, KEY_UNLOCK);
      wr(OFF_CTRL, 32'h18);
      @(negedge osc);
      wr(OFF_RELOAD, 32'h5);
      apb(1'b0, OFF_STATUS, '0);
      chk("reload busy set", 32'h2, rd & 32'h2);
      wait_free(32'h7);
      rdchk("control", OFF_CTRL, 32'h18);
      @(negedge osc);
      wr(OFF_KEY, KEY_REFRESH);
      apb(1'b0, OFF_STATUS, '0);
      chk("reloading", 32'h20, rd & 32'h20);
      wait_free(32'h20);
      apb(1'b0, OFF_COUNT, '0);
      chk("count reload", 1, rd <= 32'h5 && rd >= 32'h4);
      wr(OFF_RELOAD, 32'h7);
      repeat (30) @(posedge mclk);
      rdchk("relocked", OFF_RELOAD, 32'h5);
   endtask

   task automatic t_period();
      int t0;
      int r0;
      for (int p = 0; p < 4; p++) begin
         wr(OFF_KEY, KEY_UNLOCK);
         wr(OFF_CTRL, 32'h18 | p);
         wait_free(32'h7);
         r0 = n_rst;
         wait_irq();
         wait_irq();
         t0 = t_irq;
         wait_irq();
         chk("period", 8 * (4 << p) * 6, t_irq - t0);
         chk("no reset", r0, n_rst);
      end
      apb(1'b0, OFF_STATUS, '0);
      chk("overflow flag", 32'h8, rd & 32'h8);
   endtask

   task automatic t_action(input logic [DATA_W-1:0] c, input int er, ei);
      int r0;
      int i0;
      wr(OFF_KEY, KEY_UNLOCK);
      wr(OFF_CTRL, c);
      wait_free(32'h7);
      r0 = n_rst;
      i0 = n_irq;
      repeat (400) @(posedge mclk);
      chk("reset pulses", er, n_rst > r0);
      chk("irq pulses", ei, n_irq > i0);
   endtask

   task automatic t_pause();
      logic [DATA_W-1:0] a;
      deep <= 1'b1;
      repeat (10) @(posedge mclk);
      apb(1'b0, OFF_COUNT, '0);
      a = rd;
      repeat (48) @(posedge mclk);
      apb(1'b0, OFF_COUNT, '0);
      chk("sleep count runs", 1, rd !== a);
      wr(OFF_KEY, KEY_UNLOCK);
      wr(OFF_CTRL, 32'h28);
      wait_free(32'h7);
      deep <= 1'b1;
      repeat (10) @(posedge mclk);
      apb(1'b0, OFF_COUNT, '0);
      a = rd;
      repeat (100) @(posedge mclk);
      rdchk("paused count", OFF_COUNT, a);
      deep <= 1'b0;
      repeat (10) @(posedge mclk);
      apb(1'b0, OFF_COUNT, '0);
      a = rd;
      repeat (48) @(posedge mclk);
      apb(1'b0, OFF_COUNT, '0);
      chk("resumed count", 1, rd !== a);
   endtask

   task automatic t_window();
      int r0;
      wr(OFF_KEY, KEY_UNLOCK);
      wr(OFF_CTRL, 32'h18);
      wr(OFF_WINDOW, 32'h2);
      wait_free(32'h7);
      rdchk("window", OFF_WINDOW, 32'h2);
      r0 = n_rst;
      wr(OFF_KEY, KEY_REFRESH);
      repeat (30) @(posedge mclk);
      chk("early refresh", r0 + 1, n_rst);
      repeat (200) begin
         apb(1'b0, OFF_COUNT, '0);
         if (rd === 32'h2) break;
      end
      r0 = n_rst;
      wr(OFF_KEY, KEY_REFRESH);
      repeat (30) @(posedge mclk);
      chk("in window refresh", r0, n_rst);
   endtask

   task automatic t_stop();
      logic [DATA_W-1:0] a;
      wr(OFF_KEY, KEY_STOP1);
      wr(OFF_KEY, KEY_UNLOCK);
      wr(OFF_KEY, KEY_STOP2);
      repeat (30) @(posedge mclk);
      apb(1'b0, OFF_STATUS, '0);
      chk("broken stop", 32'h10, rd & 32'h10);
      wr(OFF_KEY, KEY_STOP1);
      wr(OFF_KEY, KEY_STOP2);
      repeat (30) @(posedge mclk);
      apb(1'b0, OFF_STATUS, '0);
      chk("stopped", '0, rd & 32'h10);
      apb(1'b0, OFF_COUNT, '0);
      a = rd;
      repeat (100) @(posedge mclk);
      rdchk("held count", OFF_COUNT, a);
      wr(OFF_KEY, KEY_START);
      repeat (30) @(posedge mclk);
      apb(1'b0, OFF_STATUS, '0);
      chk("restart", 32'h10, rd & 32'h18);
      apb(1'b0, OFF_COUNT, '0);
      chk("restart count", 1, rd > 32'hff0 && rd <= 32'hfff);
   endtask

   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_start();
      t_config();
      t_period();
      t_action(32'h00, 1, 0);
      t_action(32'h08, 0, 0);
      t_pause();
      t_window();
      t_stop();
      final_report();
   end

   initial begin
      repeat (60000) @(posedge mclk);
      err_count++;
      final_report();
   end

endmodule // tb

`default_nettype wire
